// >>> rtl/prs_pkg.sv
// Shared constants and state types for the pressure readout link
package prs_pkg;
    localparam int CLK_FREQ_MHZ = 25;
    localparam int CONV_PERIOD_US = 1000;
    localparam int CONV_CYCLES = CONV_PERIOD_US * CLK_FREQ_MHZ;
    localparam int SCL_FREQ_KHZ = 100;
    // Round down so the bus never runs slower than the chosen rate
    localparam int SCL_QUARTER_CYCLES = (CLK_FREQ_MHZ * 1000) / (4 * SCL_FREQ_KHZ);
    localparam int WORD_W = 15;
    localparam int ADDR_W = 7;
    localparam int BYTE_W = 8;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [6:0] DEFAULT_ADDR = 7'h78;
    localparam logic RW_WRITE = 1'b0;
    localparam logic RW_READ = 1'b1;
    localparam logic [14:0] PRESSURE_MIN = 15'h0666;
    localparam logic [14:0] PRESSURE_FULL = 15'h6ccc;
    localparam logic [14:0] FULL_SCALE_SPAN = 15'h6666;
    localparam logic [1:0] BYTE_ADDR = 2'h0;
    localparam logic [1:0] BYTE_HIGH = 2'h1;
    localparam logic [1:0] BYTE_LOW = 2'h2;
    localparam logic [1:0] Q0 = 2'h0;
    localparam logic [1:0] Q1 = 2'h1;
    localparam logic [1:0] Q2 = 2'h2;
    localparam logic [1:0] Q3 = 2'h3;

    typedef enum logic [2:0] {
        DS_IDLE,
        DS_ADDR,
        DS_ACK_ADDR,
        DS_WRITE,
        DS_ACK_WR,
        DS_READ,
        DS_ACK_RD
    } prs_dev_state_e;

    typedef enum logic [1:0] {
        MS_IDLE,
        MS_START,
        MS_BIT,
        MS_STOP
    } prs_mst_state_e;
endpackage : prs_pkg

// >>> rtl/prs_link_if.sv
// Two-wire link between the bus master end and the sensor end
`timescale 1ns/1ps
interface prs_link_if;
    logic mst_scl_oe;
    logic mst_scl_out;
    logic mst_sda_oe;
    logic mst_sda_out;
    logic dev_sda_oe;
    logic dev_sda_out;
    logic scl;
    logic sda;

    // Open-drain wires with pull-ups: low while any enabled driver sends a zero
    assign scl = ~(mst_scl_oe & ~mst_scl_out);
    assign sda = ~((mst_sda_oe & ~mst_sda_out) | (dev_sda_oe & ~dev_sda_out));

    modport dev (
        input scl,
        input sda,
        output dev_sda_oe,
        output dev_sda_out
    );

    modport mst (
        input scl,
        input sda,
        output mst_scl_oe,
        output mst_scl_out,
        output mst_sda_oe,
        output mst_sda_out
    );
endinterface : prs_link_if

// >>> rtl/prs_dev.sv
// Sensor end: cyclic pressure update and two-wire read-only slave
// Summary of operation
// - Store new 15-bit pressure word every millisecond.
// - Slave only; never drives clock or starts.
// - Both lines released and high when idle.
// - SDA falling while SCL high starts transaction.
// - SDA rising while SCL high ends, idle.
// - Repeated start accepted without intervening stop.
// - SDA changes only while SCL low.
// - Bytes MSB first, receiver acknowledges ninth pulse.
// - Master not acknowledging: slave releases SDA.
// - Default address 1111000, last bit direction.
// - Optional secondary address also matched, acknowledged.
// - First byte: address then direction, 1 reads.
// - Read returns two bytes of latest word.
// - Nominal word 0666 low, 6ccc full scale.
`timescale 1ns/1ps
module prs_dev #(
    parameter int CONV_CYCLES = prs_pkg::CONV_CYCLES,
    parameter bit SEC_ADDR_EN = 1'b0,
    parameter logic [6:0] SEC_ADDR = 7'h00
) (
    // System clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Link, clocked by its own serial clock
    prs_link_if.dev link,
    // Corrected pressure from the conversion path
    input wire logic [prs_pkg::WORD_W-1:0] i_pressure,
    // Word currently held in the output registers
    output logic [prs_pkg::WORD_W-1:0] o_word
);
    localparam int CW = $clog2(CONV_CYCLES);

    function automatic logic addr_match(input logic [prs_pkg::ADDR_W-1:0] a);
        addr_match = (a == prs_pkg::DEFAULT_ADDR) || (SEC_ADDR_EN && (a == SEC_ADDR));
    endfunction : addr_match

    function automatic logic [prs_pkg::BYTE_W-1:0] tx_byte(input logic sel, input logic [14:0] w);
        tx_byte = sel ? w[7:0] : {1'b0, w[14:8]};
    endfunction : tx_byte

    // System domain: conversion cycle and word publication
    logic [CW-1:0] conv_cnt;
    logic [CW-1:0] next_conv_cnt;
    logic [14:0] hold_word;
    logic [14:0] next_hold_word;
    logic [14:0] pub_word;
    logic [14:0] next_pub_word;
    logic pub_tog;
    logic next_pub_tog;
    logic fresh;
    logic next_fresh;
    logic ack_meta;
    logic ack_sync;
    logic tick;
    logic publish;

    // Serial clock domain
    prs_pkg::prs_dev_state_e state;
    prs_pkg::prs_dev_state_e next_state;
    logic [2:0] cnt;
    logic [2:0] next_cnt;
    logic [6:0] shreg;
    logic [6:0] next_shreg;
    logic rw;
    logic next_rw;
    logic byte_sel;
    logic next_byte_sel;
    logic [14:0] word_scl;
    logic [14:0] next_word_scl;
    logic [14:0] tx_word;
    logic [14:0] next_tx_word;
    logic pub_meta;
    logic pub_sync;
    logic pub_seen;
    logic next_pub_seen;
    logic start_ack;
    logic next_start_ack;
    logic stop_ack;
    logic next_stop_ack;
    logic sda_oe;
    logic next_sda_oe;
    logic [prs_pkg::BYTE_W-1:0] tx_cur;

    // Line-event domain, clocked by the data line itself
    logic start_tog;
    logic next_start_tog;
    logic stop_tog;
    logic next_stop_tog;

    always_comb begin
        tick = (conv_cnt == CW'(CONV_CYCLES - 1));
        next_conv_cnt = tick ? '0 : conv_cnt + 1'b1;
        next_hold_word = tick ? i_pressure : hold_word;
        // A word waits until the link side has taken the previous one
        publish = fresh && (ack_sync == pub_tog);
        next_fresh = tick || (fresh && !publish);
        next_pub_word = publish ? hold_word : pub_word;
        next_pub_tog = publish ? ~pub_tog : pub_tog;
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            conv_cnt <= '0;
            hold_word <= prs_pkg::PRESSURE_MIN;
            pub_word <= prs_pkg::PRESSURE_MIN;
            pub_tog <= 1'b0;
            fresh <= 1'b0;
            ack_meta <= 1'b0;
            ack_sync <= 1'b0;
        end else begin
            conv_cnt <= next_conv_cnt;
            hold_word <= next_hold_word;
            pub_word <= next_pub_word;
            pub_tog <= next_pub_tog;
            fresh <= next_fresh;
            ack_meta <= pub_seen;
            ack_sync <= ack_meta;
        end
    end

    assign o_word = hold_word;

    // Any change of SDA while SCL is high is a start or a stop
    always_comb begin
        next_start_tog = link.scl ? ~start_tog : start_tog;
        next_stop_tog = link.scl ? ~stop_tog : stop_tog;
    end

    always_ff @(negedge link.sda or posedge i_reset) begin
        if (i_reset) begin
            start_tog <= 1'b0;
        end else begin
            start_tog <= next_start_tog;
        end
    end

    always_ff @(posedge link.sda or posedge i_reset) begin
        if (i_reset) begin
            stop_tog <= 1'b0;
        end else begin
            stop_tog <= next_stop_tog;
        end
    end

    // Start and stop toggles are read without a synchroniser: the line
    // timing puts a whole SCL high-to-low-to-high interval between the event
    // and the next rising edge, and waiting two edges would lose a bit.
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_shreg = shreg;
        next_rw = rw;
        next_byte_sel = byte_sel;
        next_tx_word = tx_word;
        next_word_scl = word_scl;
        next_pub_seen = pub_seen;
        next_start_ack = start_ack;
        next_stop_ack = stop_ack;
        if (pub_sync != pub_seen) begin
            next_word_scl = pub_word;
            next_pub_seen = pub_sync;
        end
        if (start_tog != start_ack) begin
            next_start_ack = start_tog;
            next_stop_ack = stop_tog;
            next_state = prs_pkg::DS_ADDR;
            next_shreg = {shreg[5:0], link.sda};
            next_cnt = 3'h1;
        end else if (stop_tog != stop_ack) begin
            next_stop_ack = stop_tog;
            next_state = prs_pkg::DS_IDLE;
        end else begin
            case (state)
                prs_pkg::DS_ADDR: begin
                    next_shreg = {shreg[5:0], link.sda};
                    next_cnt = cnt + 1'b1;
                    if (cnt == prs_pkg::LAST_BIT) begin
                        next_rw = link.sda;
                        next_state = addr_match(shreg) ? prs_pkg::DS_ACK_ADDR : prs_pkg::DS_IDLE;
                    end
                end
                prs_pkg::DS_ACK_ADDR: begin
                    next_cnt = '0;
                    next_byte_sel = 1'b0;
                    next_tx_word = word_scl;
                    next_state = (rw == prs_pkg::RW_READ) ? prs_pkg::DS_READ : prs_pkg::DS_WRITE;
                end
                prs_pkg::DS_WRITE: begin
                    // Written bytes carry no meaning here; they are acknowledged and dropped
                    next_cnt = cnt + 1'b1;
                    if (cnt == prs_pkg::LAST_BIT) begin
                        next_state = prs_pkg::DS_ACK_WR;
                    end
                end
                prs_pkg::DS_ACK_WR: begin
                    next_cnt = '0;
                    next_state = prs_pkg::DS_WRITE;
                end
                prs_pkg::DS_READ: begin
                    next_cnt = cnt + 1'b1;
                    if (cnt == prs_pkg::LAST_BIT) begin
                        next_state = prs_pkg::DS_ACK_RD;
                    end
                end
                prs_pkg::DS_ACK_RD: begin
                    next_cnt = '0;
                    if (link.sda) begin
                        next_state = prs_pkg::DS_IDLE;
                    end else begin
                        next_byte_sel = ~byte_sel;
                        next_state = prs_pkg::DS_READ;
                    end
                end
                default: begin
                    next_state = prs_pkg::DS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge link.scl or posedge i_reset) begin
        if (i_reset) begin
            state <= prs_pkg::DS_IDLE;
            cnt <= '0;
            shreg <= '0;
            rw <= prs_pkg::RW_WRITE;
            byte_sel <= 1'b0;
            tx_word <= prs_pkg::PRESSURE_MIN;
            word_scl <= prs_pkg::PRESSURE_MIN;
            pub_meta <= 1'b0;
            pub_sync <= 1'b0;
            pub_seen <= 1'b0;
            start_ack <= 1'b0;
            stop_ack <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            shreg <= next_shreg;
            rw <= next_rw;
            byte_sel <= next_byte_sel;
            tx_word <= next_tx_word;
            word_scl <= next_word_scl;
            pub_meta <= pub_tog;
            pub_sync <= pub_meta;
            pub_seen <= next_pub_seen;
            start_ack <= next_start_ack;
            stop_ack <= next_stop_ack;
        end
    end

    // Drive on the falling edge so SDA is settled for the whole high phase
    always_comb begin
        tx_cur = tx_byte(byte_sel, tx_word);
        case (state)
            prs_pkg::DS_ACK_ADDR: next_sda_oe = 1'b1;
            prs_pkg::DS_ACK_WR: next_sda_oe = 1'b1;
            prs_pkg::DS_READ: next_sda_oe = ~tx_cur[prs_pkg::LAST_BIT - cnt];
            default: next_sda_oe = 1'b0;
        endcase
    end

    always_ff @(negedge link.scl or posedge i_reset) begin
        if (i_reset) begin
            sda_oe <= 1'b0;
        end else begin
            sda_oe <= next_sda_oe;
        end
    end

    assign link.dev_sda_oe = sda_oe;
    // Open drain: only ever pulls low, and there is no clock output at all
    assign link.dev_sda_out = 1'b0;
endmodule : prs_dev

// >>> rtl/prs_mst.sv
// Bus master end: issues address-read requests and collects the pressure word
`timescale 1ns/1ps
module prs_mst (
    // System clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Link
    prs_link_if.mst link,
    // Request
    input wire logic i_req,
    input wire logic [prs_pkg::ADDR_W-1:0] i_addr,
    // Answer
    output logic o_busy,
    output logic o_done,
    output logic o_nack,
    output logic [prs_pkg::WORD_W-1:0] o_word
);
    localparam int QW = $clog2(prs_pkg::SCL_QUARTER_CYCLES);

    prs_pkg::prs_mst_state_e state;
    prs_pkg::prs_mst_state_e next_state;
    logic [QW-1:0] qcnt;
    logic [QW-1:0] next_qcnt;
    logic [1:0] q;
    logic [1:0] next_q;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [1:0] byte_no;
    logic [1:0] next_byte_no;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [6:0] word_hi;
    logic [6:0] next_word_hi;
    logic [14:0] word;
    logic [14:0] next_word;
    logic [6:0] addr;
    logic [6:0] next_addr;
    logic scl_oe;
    logic next_scl_oe;
    logic sda_oe;
    logic next_sda_oe;
    logic done;
    logic next_done;
    logic nack;
    logic next_nack;
    logic sda_meta;
    logic sda_sync;
    logic tick;
    logic drive_low;

    always_comb begin
        tick = (qcnt == QW'(prs_pkg::SCL_QUARTER_CYCLES - 1));
        next_qcnt = (state == prs_pkg::MS_IDLE || tick) ? '0 : qcnt + 1'b1;
        next_state = state;
        next_q = q;
        next_bit_cnt = bit_cnt;
        next_byte_no = byte_no;
        next_shreg = shreg;
        next_word_hi = word_hi;
        next_word = word;
        next_addr = addr;
        next_scl_oe = scl_oe;
        next_sda_oe = sda_oe;
        next_done = 1'b0;
        next_nack = nack;
        // Address byte is sent; data bytes are released, ack first, nack last
        if (bit_cnt < prs_pkg::ACK_BIT) begin
            drive_low = (byte_no == prs_pkg::BYTE_ADDR) && !shreg[7];
        end else begin
            drive_low = (byte_no == prs_pkg::BYTE_HIGH);
        end
        case (state)
            prs_pkg::MS_IDLE: begin
                next_scl_oe = 1'b0;
                next_sda_oe = 1'b0;
                next_q = prs_pkg::Q0;
                if (i_req) begin
                    next_addr = i_addr;
                    next_nack = 1'b0;
                    next_state = prs_pkg::MS_START;
                end
            end
            prs_pkg::MS_START: begin
                if (tick) begin
                    next_q = q + 1'b1;
                    case (q)
                        prs_pkg::Q0: next_sda_oe = 1'b1;
                        prs_pkg::Q1: next_scl_oe = 1'b1;
                        prs_pkg::Q3: begin
                            next_state = prs_pkg::MS_BIT;
                            next_bit_cnt = '0;
                            next_byte_no = prs_pkg::BYTE_ADDR;
                            next_shreg = {addr, prs_pkg::RW_READ};
                        end
                        default: next_q = q + 1'b1;
                    endcase
                end
            end
            prs_pkg::MS_BIT: begin
                if (tick) begin
                    next_q = q + 1'b1;
                    case (q)
                        prs_pkg::Q0: next_sda_oe = drive_low;
                        prs_pkg::Q1: next_scl_oe = 1'b0;
                        prs_pkg::Q3: begin
                            next_scl_oe = 1'b1;
                            if (bit_cnt < prs_pkg::ACK_BIT) begin
                                next_shreg = {shreg[6:0], sda_sync};
                                next_bit_cnt = bit_cnt + 1'b1;
                            end else begin
                                next_bit_cnt = '0;
                                if (byte_no == prs_pkg::BYTE_ADDR) begin
                                    next_nack = sda_sync;
                                    next_byte_no = prs_pkg::BYTE_HIGH;
                                    next_state = sda_sync ? prs_pkg::MS_STOP : prs_pkg::MS_BIT;
                                end else if (byte_no == prs_pkg::BYTE_HIGH) begin
                                    next_word_hi = shreg[6:0];
                                    next_byte_no = prs_pkg::BYTE_LOW;
                                end else begin
                                    next_word = {word_hi, shreg};
                                    next_state = prs_pkg::MS_STOP;
                                end
                            end
                        end
                        default: next_q = q + 1'b1;
                    endcase
                end
            end
            prs_pkg::MS_STOP: begin
                if (tick) begin
                    next_q = q + 1'b1;
                    case (q)
                        prs_pkg::Q0: next_sda_oe = 1'b1;
                        prs_pkg::Q1: next_scl_oe = 1'b0;
                        prs_pkg::Q2: next_sda_oe = 1'b0;
                        default: begin
                            next_state = prs_pkg::MS_IDLE;
                            next_done = 1'b1;
                        end
                    endcase
                end
            end
            default: next_state = prs_pkg::MS_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            state <= prs_pkg::MS_IDLE;
            qcnt <= '0;
            q <= prs_pkg::Q0;
            bit_cnt <= '0;
            byte_no <= prs_pkg::BYTE_ADDR;
            shreg <= '0;
            word_hi <= '0;
            word <= '0;
            addr <= prs_pkg::DEFAULT_ADDR;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            done <= 1'b0;
            nack <= 1'b0;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
        end else begin
            state <= next_state;
            qcnt <= next_qcnt;
            q <= next_q;
            bit_cnt <= next_bit_cnt;
            byte_no <= next_byte_no;
            shreg <= next_shreg;
            word_hi <= next_word_hi;
            word <= next_word;
            addr <= next_addr;
            scl_oe <= next_scl_oe;
            sda_oe <= next_sda_oe;
            done <= next_done;
            nack <= next_nack;
            sda_meta <= link.sda;
            sda_sync <= sda_meta;
        end
    end

    assign link.mst_scl_oe = scl_oe;
    assign link.mst_scl_out = 1'b0;
    assign link.mst_sda_oe = sda_oe;
    assign link.mst_sda_out = 1'b0;
    assign o_busy = (state != prs_pkg::MS_IDLE);
    assign o_done = done;
    assign o_nack = nack;
    assign o_word = word;
endmodule : prs_mst

// >>> test/prs_link_chk.sv
// Protocol checker watching the link between the master end and the sensor end
`timescale 1ns/1ps
module prs_link_chk #(
    parameter logic [6:0] SEC_ADDR = 7'h00
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Link signals
    input wire logic scl,
    input wire logic sda,
    input wire logic mst_sda_oe,
    input wire logic dev_sda_oe
);
    logic [1:0] lq;
    logic [1:0] next_lq;
    logic [4:0] nr;
    logic [4:0] next_nr;
    logic [7:0] sh;
    logic [7:0] next_sh;
    logic rdm;
    logic next_rdm;
    logic rise;
    logic hit;

    // Rising clock edges are counted since the last start; sampling on the
    // system clock is safe because the master moves the clock on that clock
    always_comb begin
        rise = scl & ~lq[1];
        hit = (sh[7:1] == prs_pkg::DEFAULT_ADDR) || (sh[7:1] == SEC_ADDR);
        next_lq = {scl, sda};
        next_nr = nr;
        next_sh = sh;
        next_rdm = rdm;
        if (scl && lq[1] && lq[0] && !sda) begin
            next_nr = 5'h0;
            next_rdm = 1'b0;
        end else if (rise && nr != 5'h1f) begin
            next_nr = nr + 5'h1;
            if (nr < 5'h8) begin
                next_sh = {sh[6:0], sda};
            end
            if (nr == 5'h8) begin
                next_rdm = sh[0] & hit;
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            lq <= 2'h3;
            nr <= 5'h1f;
            sh <= 8'h00;
            rdm <= 1'b0;
        end else begin
            lq <= next_lq;
            nr <= next_nr;
            sh <= next_sh;
            rdm <= next_rdm;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    dev_edge_low_a: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("device data moved while clock high");
    stop_idle_a: assert property (scl && $rose(sda) |=> (scl && sda && !dev_sda_oe && !mst_sda_oe) [*8])
        else $error("lines not released after stop");
    start_hold_a: assert property (scl && $fell(sda) |-> !sda throughout (##[1:100] !scl))
        else $error("start not followed by clock low");
    addr_ack_a: assert property (rise && nr == 5'h8 && hit |-> dev_sda_oe)
        else $error("own address not acknowledged");
    addr_nack_a: assert property (rise && nr == 5'h8 && !hit |-> !dev_sda_oe)
        else $error("foreign address acknowledged");
    top_bit_zero_a: assert property (rise && nr == 5'h9 && rdm |-> dev_sda_oe && !sda)
        else $error("first data bit not zero");
    ack_slot_free_a: assert property (rise && (nr == 5'h11 || nr == 5'h1a) && rdm |-> !dev_sda_oe)
        else $error("device holds data in master ack slot");
    nack_release_a: assert property (rise && nr == 5'h1a && rdm && sda |=> (!dev_sda_oe) [*8])
        else $error("device drives after master nack");
endmodule : prs_link_chk

// >>> test/i2c_pressure_readout_slave_test.sv
// Bench: master and sensor ends joined, plus a bit-banged second link
`timescale 1ns/1ps
module i2c_pressure_readout_slave_test;
    localparam int CONV = 50;
    localparam logic [6:0] SEC = 7'h2a;
    logic i_clk_sys = 1'b0;
    logic i_reset = 1'b0;
    logic i_req = 1'b0;
    logic [6:0] i_addr = 7'h00;
    logic [14:0] pres = 15'h0000;
    // Last value differs from the reset word so the second link must really carry it
    logic [14:0] vals [3] = '{15'h7fff, 15'h0666, 15'h6ccc};
    logic busy, done, nack;
    logic [14:0] mst_word, dev_word, dev2_word;
    logic [8:0] rx;
    logic [7:0] hi;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;

    prs_link_if link ();
    prs_link_if link2 ();
    prs_dev #(.CONV_CYCLES(CONV), .SEC_ADDR_EN(1'b1), .SEC_ADDR(SEC)) u_prs_dev (.i_clk_sys(i_clk_sys),
        .i_reset(i_reset), .link(link), .i_pressure(pres), .o_word(dev_word));
    prs_dev #(.CONV_CYCLES(CONV)) u_prs_dev_2 (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .link(link2),
        .i_pressure(pres), .o_word(dev2_word));
    prs_mst u_prs_mst (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .link(link), .i_req(i_req),
        .i_addr(i_addr), .o_busy(busy), .o_done(done), .o_nack(nack), .o_word(mst_word));
    prs_link_chk #(.SEC_ADDR(SEC)) u_prs_link_chk (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
        .scl(link.scl), .sda(link.sda), .mst_sda_oe(link.mst_sda_oe), .dev_sda_oe(link.dev_sda_oe));

    always #20 i_clk_sys = ~i_clk_sys;

    // Each full read takes about 7200 cycles; eight reads stay well inside this
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 70000) begin
            num_errors++;
            $display("BAD %0t timeout", $time);
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (num_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [14:0] got, input logic [14:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic mread(input logic [6:0] a);
        int n;
        n = 0;
        @(posedge i_clk_sys);
        #1 i_req = 1'b1;
        i_addr = a;
        @(posedge i_clk_sys);
        #1 i_req = 1'b0;
        chk({14'h0, busy}, 15'h1, "busy after request");
        do begin
            @(posedge i_clk_sys);
            #1 n++;
        end while (done !== 1'b1 && n < 9000);
        if (done !== 1'b1) begin
            num_errors++;
            $display("BAD %0t read never completed", $time);
        end
        chk({14'h0, busy}, 15'h0, "busy after done");
        @(posedge i_clk_sys);
        #1;
    endtask : mread

    // Second link: the bench is the master, clock period 125 ns
    task automatic bcond(input logic stop);
        #31.25 link2.mst_sda_oe = stop;
        #31.25 link2.mst_scl_oe = 1'b0;
        #31.25 link2.mst_sda_oe = ~stop;
        #31.25 link2.mst_scl_oe = ~stop;
    endtask : bcond

    task automatic bit9(input logic [8:0] tx, output logic [8:0] got);
        for (int i = 8; i >= 0; i--) begin
            #31.25 link2.mst_sda_oe = ~tx[i];
            #31.25 link2.mst_scl_oe = 1'b0;
            #31.25 got[i] = link2.sda;
            #31.25 link2.mst_scl_oe = 1'b1;
        end
    endtask : bit9

    initial begin
        link2.mst_scl_oe = 1'b0;
        link2.mst_scl_out = 1'b0;
        link2.mst_sda_oe = 1'b0;
        link2.mst_sda_out = 1'b0;
        // A real rising edge, so flops clocked by the link lines are cleared too
        #1 i_reset = 1'b1;
        repeat (20) @(posedge i_clk_sys);
        #1 i_reset = 1'b0;
        chk(dev_word, 15'h0666, "reset word");
        chk({13'h0, link.scl, link.sda}, 15'h3, "idle lines");
        foreach (vals[i]) begin
            pres = vals[i];
            repeat (CONV + 4) @(posedge i_clk_sys);
            #1 chk(dev_word, vals[i], "stored word");
            mread(prs_pkg::DEFAULT_ADDR);
            mread(prs_pkg::DEFAULT_ADDR);
            chk(mst_word, vals[i], "read word");
            chk({14'h0, nack}, 15'h0, "address ack");
        end
        mread(SEC);
        chk({14'h0, nack}, 15'h0, "secondary ack");
        mread(7'h79);
        chk({14'h0, nack}, 15'h1, "foreign address");
        // Throwaway frame lets the snapshot reach the link domain
        bcond(1'b0);
        bit9(9'h1e3, rx);
        bit9(9'h1fe, rx);
        bit9(9'h1fe, rx);
        bit9(9'h1ff, rx);
        bcond(1'b0);
        bit9(9'h1e3, rx);
        chk({14'h0, rx[0]}, 15'h0, "restart ack");
        bit9(9'h1fe, rx);
        hi = rx[8:1];
        bit9(9'h1ff, rx);
        chk({hi[6:0], rx[8:1]}, vals[2], "restart word");
        chk({14'h0, hi[7]}, 15'h0, "top bit");
        #31.25 chk({14'h0, link2.dev_sda_oe}, 15'h0, "release on nack");
        bcond(1'b0);
        bit9(9'h1e1, rx);
        chk({14'h0, rx[0]}, 15'h0, "write address ack");
        bit9(9'h0b5, rx);
        chk({14'h0, rx[0]}, 15'h0, "write data ack");
        bcond(1'b1);
        #100 chk({12'h0, link2.scl, link2.sda, link2.dev_sda_oe}, 15'h6, "idle after stop");
        wrap_up();
    end
endmodule : i2c_pressure_readout_slave_test
